/* serial_port_two_infrared_pkg.sv */
// constants, types and register map for the second serial port infrared configuration block
package serial_port_two_infrared_pkg;

   // -----
   // register indices (byte address is four times the index)
   // -----
   localparam logic [7:0]  PORT_MODE_INDEX      = 8'hF0;
   localparam logic [7:0]  IR_OPTION_INDEX      = 8'hF1;
   localparam logic [7:0]  IR_TIMEOUT_INDEX     = 8'hF2;
   localparam int          AXI_ADDR_WIDTH       = 12;

   // -----
   // field positions and reset values
   // -----
   localparam int          MIDI_ENABLE_BIT      = 0;
   localparam int          HIGH_SPEED_BIT       = 1;
   localparam int          TX_IDLE_SELECT_BIT   = 5;
   localparam logic [7:0]  PORT_MODE_RESET      = 8'h00;
   localparam logic [7:0]  IR_OPTION_RESET      = 8'h02;
   localparam logic [7:0]  IR_OPTION_WRITE_MASK = 8'h7F;
   localparam logic [7:0]  IR_TIMEOUT_RESET     = 8'h03;

   // -----
   // axi responses
   // -----
   localparam logic [1:0]  RESP_OKAY            = 2'h0;
   localparam logic [1:0]  RESP_SLVERR          = 2'h2;

   // -----
   // timing
   // -----
   localparam int          CLK_PERIOD_NS        = 20;
   localparam int          BLANK_STEP_TIME_US   = 100;
   localparam int          BLANK_MAX_TIME_MS    = 10;
   localparam int          BLANK_STEP_CYCLES    = (BLANK_STEP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  BLANK_MAX_STEPS      = 8'((BLANK_MAX_TIME_MS * 1000) / BLANK_STEP_TIME_US);
   localparam logic [12:0] BLANK_STEP_CYCLES_13 = 13'(BLANK_STEP_CYCLES);
   localparam logic [5:0]  ASK_HALF_PERIOD      = 6'h32;

   // -----
   // types
   // -----
   typedef enum logic [2:0] {
      MODE_STANDARD = 3'h0,
      MODE_IRDA     = 3'h1,
      MODE_ASK      = 3'h2
   } ir_mode_t;

   typedef struct packed {
      logic       reserved;
      logic       alt_pins;
      logic [2:0] mode;
      logic       half_duplex;
      logic       tx_active_low;
      logic       rx_active_low;
   } ir_option_t;

   typedef struct packed {
      logic [AXI_ADDR_WIDTH-1:0] addr;
      logic [31:0]               data;
      logic [3:0]                strb;
   } write_req_t;

endpackage

/* half_duplex_blanker.sv */
// receive blanking timer for half-duplex infrared operation
`timescale 1ns/100ps
module half_duplex_blanker
   import serial_port_two_infrared_pkg::*;
#(
   parameter logic [12:0] step_cycles = BLANK_STEP_CYCLES_13
)(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       enable,
   input  wire logic       tx_busy,
   input  wire logic [7:0] timeout_steps,
   output      logic       blank
);

   logic [12:0] prescale;
   logic [7:0]  steps_left;

   // -----
   // step counter, reloaded while the port transmits
   // -----
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable)
      begin
         prescale   <= 13'h0000;
         steps_left <= 8'h00;
      end
      else if (tx_busy)
      begin
         prescale   <= 13'h0000;
         // values past the ten millisecond ceiling are clamped
         steps_left <= (timeout_steps > BLANK_MAX_STEPS) ? BLANK_MAX_STEPS : timeout_steps;
      end
      else if (steps_left != 8'h00)
      begin
         if (prescale == step_cycles - 13'h0001)
         begin
            prescale   <= 13'h0000;
            steps_left <= steps_left - 8'h01;
         end
         else
         begin
            prescale <= prescale + 13'h0001;
         end
      end
   end

   // zero steps blanks only while transmitting
   assign blank = enable && (tx_busy || steps_left != 8'h00);

endmodule // half_duplex_blanker

/* serial_port_two_infrared_config.sv */
// second serial port configuration registers and infrared front end
// What this block does
// - port mode bit 0 enables midi support; reset leaves it disabled
// - port mode bit 1 enables high-speed operation; reset leaves it disabled
// - port mode bit 5: tx pin low when idle if 0, released if 1, except in infrared modes on the main pins, which always drive it
// - tx idle bit is cleared only by standby power-on reset
// - option bit 0 selects receive polarity, active high after reset
// - option bit 1 selects transmit polarity, active low after reset
// - option bit 2 selects half duplex; full duplex after reset
// - option bits 5:3 choose standard, irda or amplitude keyed protocol
// - option bit 6 moves infrared traffic to the alternate optical pins
// - timeout register sets blanking in 100 us steps up to 10 ms
`timescale 1ns/100ps
module serial_port_two_infrared_config
   import serial_port_two_infrared_pkg::*;
#(
   parameter logic [12:0] blank_step_cycles = BLANK_STEP_CYCLES_13
)(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      standby_power_on_reset_n,
   // axi4-lite slave
   input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output      logic                      s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output      logic                      s_axi_wready,
   output      logic [1:0]                s_axi_bresp,
   output      logic                      s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output      logic                      s_axi_arready,
   output      logic [31:0]               s_axi_rdata,
   output      logic [1:0]                s_axi_rresp,
   output      logic                      s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // uart core side
   input  wire logic                      core_tx,
   input  wire logic                      core_tx_busy,
   output      logic                      core_rx,
   output      logic                      midi_enable,
   output      logic                      high_speed_enable,
   // pins
   output      logic                      serial_tx_out,
   output      logic                      serial_tx_oe,
   input  wire logic                      serial_rx_in,
   output      logic                      alt_optical_tx_out,
   input  wire logic                      alt_optical_rx_in
);

   // -----
   // helpers
   // -----
   function automatic logic [7:0] reg_index(input logic [AXI_ADDR_WIDTH-1:0] addr);
      reg_index = addr[9:2];
   endfunction

   function automatic logic is_mapped(input logic [AXI_ADDR_WIDTH-1:0] addr);
      logic [7:0] idx;
      idx = reg_index(addr);
      is_mapped = (addr[AXI_ADDR_WIDTH-1:10] == 2'h0)
               && (idx == PORT_MODE_INDEX || idx == IR_OPTION_INDEX || idx == IR_TIMEOUT_INDEX);
   endfunction

   function automatic logic is_optical(input logic [2:0] mode);
      // reserved codes fall back to plain serial behaviour
      is_optical = (mode == MODE_IRDA) || (mode == MODE_ASK);
   endfunction

   // -----
   // state
   // -----
   typedef enum logic {
      WR_COLLECT,
      WR_RESPOND
   } write_state_t;

   write_state_t write_state;
   write_req_t   wr_req;
   logic [11:0]  wr_addr;
   logic [31:0]  wr_data;
   logic [3:0]   wr_strb;
   logic         aw_held;
   logic         w_held;
   logic         commit;
   logic         midi_bit;
   logic         high_speed_bit;
   logic         tx_idle_tristate;
   ir_option_t   ir_option;
   logic [7:0]   ir_timeout;
   logic         bus_reset_n;
   logic         blank;
   logic         carrier;
   logic [5:0]   carrier_count;
   logic         rx_source;
   logic         rx_pulse;
   logic         tx_pulse;
   logic         tx_level;
   logic         optical;

   // main power-on reset, hard reset and standby power-on reset all clear the bus side
   assign bus_reset_n = aresetn && standby_power_on_reset_n;
   assign commit      = (write_state == WR_COLLECT) && aw_held && w_held;
   assign wr_req      = '{addr: wr_addr, data: wr_data, strb: wr_strb};

   // -----
   // write address and data capture, either order
   // -----
   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         s_axi_awready <= 1'b1;
         aw_held       <= 1'b0;
         wr_addr       <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         s_axi_awready <= 1'b0;
         aw_held       <= 1'b1;
         wr_addr       <= s_axi_awaddr;
      end
      else if (commit)
      begin
         aw_held <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         s_axi_wready <= 1'b1;
         w_held       <= 1'b0;
         wr_data      <= 32'h0000_0000;
         wr_strb      <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         s_axi_wready <= 1'b0;
         w_held       <= 1'b1;
         wr_data      <= s_axi_wdata;
         wr_strb      <= s_axi_wstrb;
      end
      else if (commit)
      begin
         w_held <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_wready <= 1'b1;
      end
   end

   // -----
   // write response
   // -----
   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         write_state  <= WR_COLLECT;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         unique case (write_state)
            WR_COLLECT:
            begin
               if (commit)
               begin
                  write_state  <= WR_RESPOND;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= is_mapped(wr_req.addr) ? RESP_OKAY : RESP_SLVERR;
               end
            end
            WR_RESPOND:
            begin
               if (s_axi_bready)
               begin
                  write_state  <= WR_COLLECT;
                  s_axi_bvalid <= 1'b0;
               end
            end
         endcase
      end
   end

   // -----
   // configuration registers, main reset domain
   // -----
   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         midi_bit       <= PORT_MODE_RESET[MIDI_ENABLE_BIT];
         high_speed_bit <= PORT_MODE_RESET[HIGH_SPEED_BIT];
      end
      else if (commit && wr_req.strb[0] && reg_index(wr_req.addr) == PORT_MODE_INDEX && is_mapped(wr_req.addr))
      begin
         midi_bit       <= wr_req.data[MIDI_ENABLE_BIT];
         high_speed_bit <= wr_req.data[HIGH_SPEED_BIT];
      end
   end

   // reserved option bit is never stored, so it reads back zero
   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         ir_option <= ir_option_t'(IR_OPTION_RESET);
      end
      else if (commit && wr_req.strb[0] && reg_index(wr_req.addr) == IR_OPTION_INDEX && is_mapped(wr_req.addr))
      begin
         ir_option <= ir_option_t'(wr_req.data[7:0] & IR_OPTION_WRITE_MASK);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         ir_timeout <= IR_TIMEOUT_RESET;
      end
      else if (commit && wr_req.strb[0] && reg_index(wr_req.addr) == IR_TIMEOUT_INDEX && is_mapped(wr_req.addr))
      begin
         ir_timeout <= wr_req.data[7:0];
      end
   end

   // -----
   // transmit idle select, standby domain only
   // -----
   // main reset and hard reset must not touch this bit
   always_ff @(posedge aclk)
   begin
      if (!standby_power_on_reset_n)
      begin
         tx_idle_tristate <= PORT_MODE_RESET[TX_IDLE_SELECT_BIT];
      end
      else if (aresetn && commit && wr_req.strb[0] && reg_index(wr_req.addr) == PORT_MODE_INDEX
               && is_mapped(wr_req.addr))
      begin
         tx_idle_tristate <= wr_req.data[TX_IDLE_SELECT_BIT];
      end
   end

   // -----
   // read channel
   // -----
   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         s_axi_rdata   <= 32'h0000_0000;
         if (is_mapped(s_axi_araddr))
         begin
            unique case (reg_index(s_axi_araddr))
               PORT_MODE_INDEX:  s_axi_rdata[7:0] <= {2'h0, tx_idle_tristate, 3'h0, high_speed_bit, midi_bit};
               IR_OPTION_INDEX:  s_axi_rdata[7:0] <= ir_option;
               IR_TIMEOUT_INDEX: s_axi_rdata[7:0] <= ir_timeout;
               default:          s_axi_rdata[7:0] <= 8'h00;
            endcase
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // -----
   // mode outputs
   // -----
   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         midi_enable       <= 1'b0;
         high_speed_enable <= 1'b0;
      end
      else
      begin
         midi_enable       <= midi_bit;
         high_speed_enable <= high_speed_bit;
      end
   end

   // -----
   // amplitude keyed carrier
   // -----
   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n || ir_option.mode != MODE_ASK)
      begin
         carrier       <= 1'b0;
         carrier_count <= 6'h00;
      end
      else if (carrier_count == ASK_HALF_PERIOD - 6'h01)
      begin
         carrier       <= ~carrier;
         carrier_count <= 6'h00;
      end
      else
      begin
         carrier_count <= carrier_count + 6'h01;
      end
   end

   // -----
   // half-duplex receive blanking
   // -----
   half_duplex_blanker #(
      .step_cycles   (blank_step_cycles)
   ) blanker (
      .aclk          (aclk),
      .aresetn       (bus_reset_n),
      .enable        (ir_option.half_duplex && optical),
      .tx_busy       (core_tx_busy),
      .timeout_steps (ir_timeout),
      .blank         (blank)
   );

   // -----
   // infrared encode and decode
   // -----
   assign optical   = is_optical(ir_option.mode);
   assign rx_source = ir_option.alt_pins ? alt_optical_rx_in : serial_rx_in;
   assign rx_pulse  = rx_source ^ ir_option.rx_active_low;
   // a zero bit is sent as light; pulse width shaping is the core's baud logic
   assign tx_pulse  = core_tx_busy && !core_tx && (ir_option.mode != MODE_ASK || carrier);
   assign tx_level  = tx_pulse ^ ir_option.tx_active_low;

   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         core_rx <= 1'b1;
      end
      else if (!optical)
      begin
         core_rx <= serial_rx_in;
      end
      else if (blank)
      begin
         // echo of our own light would otherwise be read as data
         core_rx <= 1'b1;
      end
      else
      begin
         core_rx <= !rx_pulse;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!bus_reset_n)
      begin
         serial_tx_out      <= 1'b0;
         // standby reset clears the idle bit at this same edge, so drive at once
         serial_tx_oe       <= !(tx_idle_tristate && standby_power_on_reset_n);
         alt_optical_tx_out <= 1'b0;
      end
      else
      begin
         alt_optical_tx_out <= (optical && ir_option.alt_pins) ? tx_level : 1'b0;
         if (optical && !ir_option.alt_pins)
         begin
            serial_tx_out <= tx_level;
            serial_tx_oe  <= 1'b1;
         end
         else if (core_tx_busy && !optical)
         begin
            serial_tx_out <= core_tx;
            serial_tx_oe  <= 1'b1;
         end
         else
         begin
            serial_tx_out <= 1'b0;
            serial_tx_oe  <= !tx_idle_tristate;
         end
      end
   end

endmodule // serial_port_two_infrared_config

/* serial_port_two_infrared_config_sva.sv */
// assertion checker for the second serial port infrared configuration block
`timescale 1ns/100ps
module serial_port_two_infrared_config_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        standby_power_on_reset_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        core_rx,
   input wire logic        midi_enable,
   input wire logic        high_speed_enable,
   input wire logic        serial_tx_out,
   input wire logic        serial_tx_oe,
   input wire logic        alt_optical_tx_out
);
   // -----
   // properties
   // -----
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !standby_power_on_reset_n);

   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after address and data");
   read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read accepted while one is pending");
   cfg_source_a: assert property (!$stable(midi_enable) || !$stable(high_speed_enable)
      |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("mode output changed without a write");
   main_reset_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && core_rx
      && !midi_enable && !high_speed_enable && !alt_optical_tx_out) else $error("main reset state wrong");
   standby_reset_a: assert property (disable iff (1'b0) !standby_power_on_reset_n
      |=> serial_tx_oe && !serial_tx_out) else $error("standby reset does not drive tx pin low");
endmodule // serial_port_two_infrared_config_checker

bind serial_port_two_infrared_config serial_port_two_infrared_config_checker chk (.aclk, .aresetn,
   .standby_power_on_reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .core_rx, .midi_enable, .high_speed_enable, .serial_tx_out, .serial_tx_oe, .alt_optical_tx_out);

/* optical_link_model.sv */
// behavioural optical transceiver driving the receive pins
`timescale 1ns/100ps
module optical_link_model (
   input  wire logic aclk,
   input  wire logic send,
   input  wire logic rx_active_low,
   input  wire logic alt_pins,
   output      logic serial_rx_in,
   output      logic alt_optical_rx_in
);
   // -----
   // receive pins
   // -----
   // the pin it does not sit on toggles so a wrong pin choice shows up
   logic toggle = 1'b0;

   always_ff @(posedge aclk)
   begin
      toggle            <= !toggle;
      serial_rx_in      <= alt_pins ? toggle : (send ^ rx_active_low);
      alt_optical_rx_in <= alt_pins ? (send ^ rx_active_low) : toggle;
   end
endmodule // optical_link_model

/* serial_port_two_infrared_config_bench.sv */
// self-checking bench for the second serial port infrared configuration block
`timescale 1ns/100ps
module serial_port_two_infrared_config_bench;
   import serial_port_two_infrared_pkg::*;
   // -----
   // signals
   // -----
   localparam logic [12:0] STEP = 13'h4;
   localparam logic [11:0] A_PM = {2'b00, PORT_MODE_INDEX, 2'b00};
   localparam logic [11:0] A_OPT = {2'b00, IR_OPTION_INDEX, 2'b00};
   localparam logic [11:0] A_TO = {2'b00, IR_TIMEOUT_INDEX, 2'b00};
   localparam logic [11:0] A_BAD = 12'h3CC;
   logic        aclk, aresetn, standby_power_on_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        core_tx, core_tx_busy, core_rx, midi_enable, high_speed_enable, serial_tx_out, serial_tx_oe;
   logic        serial_rx_in, alt_optical_tx_out, alt_optical_rx_in, send, rx_low, alt_sel;
   int          errors, n_checks;

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end

   serial_port_two_infrared_config #(.blank_step_cycles(STEP)) dut (.aclk, .aresetn, .standby_power_on_reset_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_tx, .core_tx_busy, .core_rx, .midi_enable,
      .high_speed_enable, .serial_tx_out, .serial_tx_oe, .serial_rx_in, .alt_optical_tx_out, .alt_optical_rx_in);
   optical_link_model link (.aclk, .send, .rx_active_low(rx_low), .alt_pins(alt_sel), .serial_rx_in,
      .alt_optical_rx_in);

   // -----
   // bus and pin tasks
   // -----
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw, w, b;
      {aw, w, b} = 3'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40 && !b; n++)
      begin
         @(posedge aclk);
         b = aw & w & s_axi_bvalid;
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end
      s_axi_bready <= 1'b0;
      `CHK("bvalid", 1'b1, b)
      `CHK("bresp", er, s_axi_bresp)
      @(posedge aclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
      logic ar, r;
      {ar, r} = 2'h0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40 && !r; n++)
      begin
         @(posedge aclk);
         r = ar & s_axi_rvalid;
         ar = ar | s_axi_arready;
         s_axi_arvalid <= !ar;
      end
      s_axi_rready <= 1'b0;
      `CHK("rdata", {24'h0, ed}, s_axi_rdata)
      `CHK("rvalid", 1'b1, r)
      `CHK("rresp", er, s_axi_rresp)
      @(posedge aclk);
   endtask

   task automatic cfg(input logic [7:0] opt);
      rx_low <= opt[0];
      alt_sel <= opt[6];
      wr(A_OPT, opt, RESP_OKAY);
   endtask

   // settles over four edges: model and design outputs are both registered
   task automatic drive(input logic busy, input logic tx, input logic s);
      core_tx_busy <= busy;
      core_tx <= tx;
      send <= s;
      repeat (4) @(posedge aclk);
   endtask

   task automatic pulse_reset(input logic standby);
      if (standby)
         standby_power_on_reset_n <= 1'b0;
      else
         aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      {aresetn, standby_power_on_reset_n} <= 2'b11;
      @(posedge aclk);
   endtask

   // -----
   // scenarios
   // -----
   task automatic t_regs;
      rd(A_PM, PORT_MODE_RESET, RESP_OKAY);
      rd(A_OPT, 8'h02, RESP_OKAY);
      rd(A_TO, 8'h03, RESP_OKAY);
      rd(A_BAD, 8'h00, RESP_SLVERR);
      wr(A_BAD, 8'hFF, RESP_SLVERR);
      wr(A_PM, 8'h03, RESP_OKAY);
      rd(A_PM, 8'h03, RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("midi", 1'b1, midi_enable)
      `CHK("speed", 1'b1, high_speed_enable)
      wr(A_PM, 8'h02, RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("midi", 1'b0, midi_enable)
      `CHK("speed", 1'b1, high_speed_enable)
      cfg(8'h7F);
      rd(A_OPT, 8'h7F, RESP_OKAY);
      wr(A_TO, 8'hA5, RESP_OKAY);
      rd(A_TO, 8'hA5, RESP_OKAY);
   endtask

   task automatic t_idle;
      cfg(8'h00);
      drive(1'b0, 1'b1, 1'b0);
      `CHK("oe", 1'b1, serial_tx_oe)
      `CHK("tx", 1'b0, serial_tx_out)
      wr(A_PM, 8'h20, RESP_OKAY);
      drive(1'b0, 1'b1, 1'b0);
      `CHK("oe", 1'b0, serial_tx_oe)
      drive(1'b1, 1'b1, 1'b0);
      `CHK("oe", 1'b1, serial_tx_oe)
      `CHK("tx", 1'b1, serial_tx_out)
      drive(1'b0, 1'b1, 1'b0);
      pulse_reset(1'b0);
      rd(A_PM, 8'h20, RESP_OKAY);
      `CHK("oe", 1'b0, serial_tx_oe)
      pulse_reset(1'b1);
      rd(A_PM, 8'h00, RESP_OKAY);
      `CHK("oe", 1'b1, serial_tx_oe)
   endtask

   // each entry: option, busy, tx bit, send, then serial tx, alt tx, core rx expected
   task automatic t_optical;
      logic [13:0] tbl [8];
      int          c;
      logic        x;
      tbl = '{{8'h00, 6'b111_101}, {8'h00, 6'b100_000}, {8'h08, 6'b101_100}, {8'h0A, 6'b100_001},
              {8'h09, 6'b011_000}, {8'h48, 6'b101_010}, {8'h48, 6'b110_001}, {8'h18, 6'b110_100}};
      foreach (tbl[i])
      begin
         cfg(tbl[i][13:6]);
         drive(tbl[i][5], tbl[i][4], tbl[i][3]);
         `CHK("tx pin", tbl[i][2], serial_tx_out)
         `CHK("alt tx pin", tbl[i][1], alt_optical_tx_out)
         `CHK("core rx", tbl[i][0], core_rx)
      end
      cfg(8'h10);
      drive(1'b1, 1'b0, 1'b0);
      c = 0;
      x = serial_tx_out;
      repeat (2 * ASK_HALF_PERIOD + 20)
      begin
         @(posedge aclk);
         c += int'(serial_tx_out !== x);
         x = serial_tx_out;
      end
      `CHK("carrier edges", 1'b1, c >= 2 && c <= 3)
   endtask

   task automatic t_half;
      wr(A_TO, 8'h02, RESP_OKAY);
      cfg(8'h0C);
      drive(1'b1, 1'b1, 1'b1);
      `CHK("core rx", 1'b1, core_rx)
      drive(1'b0, 1'b1, 1'b1);
      `CHK("core rx", 1'b1, core_rx)
      repeat (10) @(posedge aclk);
      `CHK("core rx", 1'b0, core_rx)
      wr(A_TO, 8'hFF, RESP_OKAY);
      drive(1'b1, 1'b1, 1'b1);
      drive(1'b0, 1'b1, 1'b1);
      repeat (390) @(posedge aclk);
      `CHK("core rx", 1'b1, core_rx)
      repeat (12) @(posedge aclk);
      `CHK("core rx", 1'b0, core_rx)
      wr(A_TO, 8'h00, RESP_OKAY);
      drive(1'b1, 1'b1, 1'b1);
      drive(1'b0, 1'b1, 1'b1);
      `CHK("core rx", 1'b0, core_rx)
      cfg(8'h08);
      drive(1'b1, 1'b1, 1'b1);
      `CHK("core rx", 1'b0, core_rx)
   endtask

   // -----
   // run control
   // -----
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // whole run is about 750 cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      print_verdict;
   end

   initial
   begin
      {aresetn, standby_power_on_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, core_tx, core_tx_busy, send, rx_low, alt_sel, errors, n_checks} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      {aresetn, standby_power_on_reset_n} <= 2'b11;
      @(posedge aclk);
      t_regs;
      t_idle;
      t_optical;
      t_half;
      print_verdict;
   end
endmodule // serial_port_two_infrared_config_bench
